// ### hw/somc_mode_ctrl.sv
// Operating-mode sequencer.
`timescale 1ns/100ps
`default_nettype none
module somc_mode_ctrl
    import somc_pkg::*;
#(
    parameter int unsigned RESET_HOLD_CYCLES = RESET_HOLD_CYC,
    parameter int unsigned WAKE_CFG_CYCLES   = WAKE_CFG_CYC,
    parameter int unsigned CYCLIC_PER_CYCLES = CYCLIC_PER_CYC,
    parameter int unsigned CYCLIC_ON_CYCLES  = CYCLIC_ON_CYC,
    parameter int unsigned WD_UNIT_CYCLES    = WD_UNIT_CYC
)
(
    // Main clock and reset.
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    // Host commands, main clock.
    input  wire logic                 cfg_wd_write_i,
    input  wire logic [WD_SEL_W-1:0]  cfg_wd_period_i,
    input  wire logic                 cfg_goto_standby_i,
    input  wire logic                 cmd_normal_i,
    input  wire logic                 cmd_standby_i,
    input  wire logic                 cmd_stop_i,
    input  wire logic                 cmd_sleep_i,
    input  wire logic                 wd_clear_i,
    input  wire logic                 switch_on_control_i,
    input  wire logic                 watchdog_in_stop_select_i,
    input  wire logic                 cyclic_sense_en_i,
    input  wire logic                 forced_wake_i,
    // Analog monitors and pins, asynchronous.
    input  wire logic                 main_uv_i,
    input  wire logic                 secondary_supply_uv_i,
    input  wire logic                 switch_overtemp_i,
    input  wire logic                 main_overcurrent_i,
    input  wire logic                 chip_select_n_i,
    input  wire logic [WAKE_IN_W-1:0] wake_inputs_i,
    // CAN link domain.
    input  wire logic                 link_clk_i,
    input  wire logic                 link_reset_i,
    input  wire logic                 can_rx_frame_i,
    // Outputs.
    output logic                      reset_n_o,
    output logic                      irq_n_o,
    output logic                      main_reg_on_o,
    output logic                      main_reg_lowpower_o,
    output logic                      pass_transistor_drive_o,
    output logic                      high_side_switch_o,
    output logic                      can_tx_enable_o,
    output logic                      slow_osc_select_o,
    output logic                      secondary_supply_low_flag_o,
    output logic                      switch_overtemp_flag_o,
    output logic                      switch_overtemp_or_supply_low_irq_flag_o,
    output logic                      bus_wake_flag_o,
    output logic [WAKE_IN_W-1:0]      wake_inputs_o,
    output var somc_mode_t            mode_o
);

    // Link domain: a received frame toggles a flag that crosses as an event.
    logic link_tog_reg;

    always_ff @(posedge link_clk_i)
    begin
        if (link_reset_i)
            link_tog_reg <= 1'b0;
        else if (can_rx_frame_i)
            link_tog_reg <= ~link_tog_reg;
    end

    typedef struct packed {
        logic [1:0]             s_uv;
        logic [1:0]             s_v2uv;
        logic [1:0]             s_ot;
        logic [1:0]             s_oc;
        logic [1:0]             s_cs;
        logic [1:0]             s_tog;
        logic [WAKE_IN_W-1:0]   s_wk0;
        logic [WAKE_IN_W-1:0]   s_wk1;
        logic                   cs_prev;
        logic                   tog_prev;
        logic [WAKE_IN_W-1:0]   wk_prev;
        somc_mode_t             mode;
        somc_origin_t           origin;
        logic [CNT_W-1:0]       tmr;
        logic [CNT_W-1:0]       wd_cnt;
        logic [CNT_W-1:0]       wd_limit;
        logic [CNT_W-1:0]       cyc_cnt;
        logic [CNT_W-1:0]       pulse_cnt;
        logic                   pulse_pending;
        logic                   reset_n;
        logic                   irq_n;
        logic                   main_on;
        logic                   main_lp;
        logic                   pass_drv;
        logic                   hs;
        logic                   can_tx;
        logic                   slow_osc;
        logic                   secondary_supply_low_flag;
        logic                   switch_overtemp_flag;
        logic                   switch_overtemp_flag_irq;
        logic                   bus_wake;
        logic [WAKE_IN_W-1:0]   wk_out;
    } somc_state_t;

    somc_state_t state_reg;
    somc_state_t state_next;

    // Watchdog period in cycles; the window is closed for the first half.
    function automatic logic [CNT_W-1:0] wd_period(input logic [WD_SEL_W-1:0] sel);
        logic [CNT_W-1:0] unit;
        unit = CNT_W'(WD_UNIT_CYCLES);
        wd_period = unit * CNT_W'({1'b0, sel} + 3'h1);
    endfunction : wd_period

    function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] v);
        dec_sat = (v == CNT_ZERO) ? CNT_ZERO : v - CNT_ONE;
    endfunction : dec_sat

    logic wake_lvl;
    logic cs_rise;
    logic can_evt;
    logic cyc_on;
    logic wd_run;
    logic wd_expire;
    logic wd_early;

    always_comb
    begin
        state_next = state_reg;
        // Every asynchronous input passes two flip-flops before any logic.
        state_next.s_uv   = {state_reg.s_uv[0], main_uv_i};
        state_next.s_v2uv = {state_reg.s_v2uv[0], secondary_supply_uv_i};
        state_next.s_ot   = {state_reg.s_ot[0], switch_overtemp_i};
        state_next.s_oc   = {state_reg.s_oc[0], main_overcurrent_i};
        state_next.s_cs   = {state_reg.s_cs[0], chip_select_n_i};
        state_next.s_tog  = {state_reg.s_tog[0], link_tog_reg};
        state_next.s_wk0  = wake_inputs_i;
        state_next.s_wk1  = state_reg.s_wk0;
        state_next.cs_prev  = state_reg.s_cs[1];
        state_next.tog_prev = state_reg.s_tog[1];
        state_next.wk_prev  = state_reg.s_wk1;

        wake_lvl = (state_reg.s_wk1 != state_reg.wk_prev);
        cs_rise  = state_reg.s_cs[1] & ~state_reg.cs_prev;
        can_evt  = state_reg.s_tog[1] ^ state_reg.tog_prev;

        state_next.cyc_cnt = (state_reg.cyc_cnt == CNT_ZERO) ? CNT_W'(CYCLIC_PER_CYCLES - 1)
                                                             : state_reg.cyc_cnt - CNT_ONE;
        cyc_on = cyclic_sense_en_i & (state_reg.cyc_cnt < CNT_W'(CYCLIC_ON_CYCLES));

        wd_run = (state_reg.mode == SOMC_NORMAL) || (state_reg.mode == SOMC_STANDBY)
                 || ((state_reg.mode == SOMC_STOP) && watchdog_in_stop_select_i);
        wd_expire = wd_run && (state_reg.wd_cnt >= state_reg.wd_limit);
        wd_early = wd_clear_i && ((state_reg.mode == SOMC_NORMAL) || (state_reg.mode == SOMC_STANDBY))
                   && (state_reg.wd_cnt < (state_reg.wd_limit >> 1));
        if (wd_run)
            state_next.wd_cnt = state_reg.wd_cnt + CNT_ONE;
        if (wd_clear_i && !wd_early)
            state_next.wd_cnt = CNT_ZERO;

        state_next.tmr = dec_sat(state_reg.tmr);
        state_next.pulse_cnt = dec_sat(state_reg.pulse_cnt);

        case (state_reg.mode)
            SOMC_RESET:
            begin
                if (state_reg.tmr == CNT_ZERO)
                begin
                    state_next.mode = SOMC_NORM_REQ;
                    state_next.tmr  = CNT_W'(WAKE_CFG_CYCLES);
                end
            end
            SOMC_NORM_REQ:
            begin
                if (cfg_wd_write_i)
                begin
                    state_next.wd_limit = wd_period(cfg_wd_period_i);
                    state_next.wd_cnt   = CNT_ZERO;
                    state_next.mode     = cfg_goto_standby_i ? SOMC_STANDBY : SOMC_NORMAL;
                end
                else if (state_reg.tmr == CNT_ZERO)
                begin
                    if (state_reg.origin == SOMC_ORIGIN_SLEEP)
                        state_next.mode = SOMC_SLEEP;
                    else
                    begin
                        state_next.mode   = SOMC_RESET;
                        state_next.origin = SOMC_ORIGIN_POWER;
                        state_next.tmr    = CNT_W'(RESET_HOLD_CYCLES);
                    end
                end
            end
            SOMC_NORMAL, SOMC_STANDBY:
            begin
                if (cmd_normal_i)
                    state_next.mode = SOMC_NORMAL;
                else if (cmd_standby_i)
                    state_next.mode = SOMC_STANDBY;
                else if (cmd_stop_i)
                    state_next.mode = SOMC_STOP;
                else if (cmd_sleep_i)
                    state_next.mode = SOMC_SLEEP;
            end
            SOMC_STOP:
            begin
                if (wake_lvl || can_evt || forced_wake_i || cs_rise || state_reg.s_oc[1]
                    || (cyc_on && wake_lvl))
                begin
                    state_next.mode   = SOMC_NORM_REQ;
                    state_next.origin = SOMC_ORIGIN_STOP;
                    state_next.tmr    = CNT_W'(WAKE_CFG_CYCLES);
                    state_next.pulse_pending = 1'b1;
                end
            end
            SOMC_SLEEP:
            begin
                if (wake_lvl || can_evt || forced_wake_i)
                begin
                    state_next.mode   = SOMC_RESET;
                    state_next.origin = SOMC_ORIGIN_SLEEP;
                    state_next.tmr    = CNT_W'(RESET_HOLD_CYCLES);
                end
            end
            default:
            begin
                state_next.mode = SOMC_RESET;
                state_next.tmr  = CNT_W'(RESET_HOLD_CYCLES);
            end
        endcase

        if ((state_reg.s_uv[1] && (state_reg.mode != SOMC_SLEEP)) || wd_expire || wd_early)
        begin
            state_next.mode   = SOMC_RESET;
            state_next.origin = SOMC_ORIGIN_POWER;
            state_next.tmr    = CNT_W'(RESET_HOLD_CYCLES);
        end

        if (state_reg.pulse_pending && (state_reg.mode == SOMC_NORM_REQ))
        begin
            state_next.pulse_pending = 1'b0;
            state_next.pulse_cnt     = CNT_W'(WAKE_PULSE_CYC);
        end
        state_next.irq_n = (state_reg.pulse_cnt == CNT_ZERO);

        state_next.reset_n = (state_next.mode != SOMC_RESET) && (state_next.mode != SOMC_SLEEP);
        state_next.pass_drv = (state_next.mode == SOMC_NORMAL);
        state_next.can_tx   = (state_next.mode == SOMC_NORMAL);
        state_next.main_on  = (state_next.mode != SOMC_SLEEP);
        state_next.main_lp  = (state_next.mode == SOMC_STOP);
        // Slow oscillator in Sleep and Stop.
        state_next.slow_osc = (state_next.mode == SOMC_SLEEP) || (state_next.mode == SOMC_STOP);

        case (state_reg.mode)
            SOMC_NORMAL, SOMC_STANDBY: state_next.hs = switch_on_control_i & ~state_reg.s_ot[1];
            SOMC_STOP, SOMC_SLEEP:     state_next.hs = cyc_on & ~state_reg.s_ot[1];
            default:                   state_next.hs = 1'b0;
        endcase

        state_next.secondary_supply_low_flag = state_reg.s_v2uv[1];
        state_next.switch_overtemp_flag     = state_reg.s_ot[1];
        state_next.switch_overtemp_flag_irq = state_reg.s_ot[1] | state_reg.s_v2uv[1];
        // Bus wake flag sticks until the host moves to Normal.
        if (can_evt && (state_reg.mode != SOMC_NORMAL))
            state_next.bus_wake = 1'b1;
        else if (cmd_normal_i)
            state_next.bus_wake = 1'b0;
        state_next.wk_out = state_reg.s_wk1;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state_reg          <= '0;
            state_reg.mode     <= SOMC_RESET;
            state_reg.origin   <= SOMC_ORIGIN_POWER;
            state_reg.tmr      <= CNT_W'(RESET_HOLD_CYCLES);
            state_reg.wd_limit <= CNT_W'(WD_UNIT_CYCLES);
            state_reg.s_cs     <= 2'h3;
            state_reg.cs_prev  <= 1'b1;
            state_reg.irq_n    <= 1'b1;
            state_reg.main_on  <= 1'b1;
        end
        else
            state_reg <= state_next;
    end

    assign reset_n_o = state_reg.reset_n;
    assign irq_n_o = state_reg.irq_n;
    assign main_reg_on_o = state_reg.main_on;
    assign main_reg_lowpower_o = state_reg.main_lp;
    assign pass_transistor_drive_o = state_reg.pass_drv;
    assign high_side_switch_o = state_reg.hs;
    assign can_tx_enable_o = state_reg.can_tx;
    assign slow_osc_select_o = state_reg.slow_osc;
    assign secondary_supply_low_flag_o = state_reg.secondary_supply_low_flag;
    assign switch_overtemp_flag_o = state_reg.switch_overtemp_flag;
    assign switch_overtemp_or_supply_low_irq_flag_o = state_reg.switch_overtemp_flag_irq;
    assign bus_wake_flag_o = state_reg.bus_wake;
    assign wake_inputs_o = state_reg.wk_out;
    assign mode_o = state_reg.mode;

endmodule : somc_mode_ctrl
`default_nettype wire

// ### hw/somc_pkg.sv
// Constants and rule summary of the mode controller.
// Function
// - Supply-low flag set while secondary supply is low.
// - Switch overtemp sets switch and combined flags.
// - Switch follows switch-on control.
// - Cyclic switch timer in Sleep and Stop.
// - Host switch control in Normal, Standby.
// - Slow oscillator only in Sleep and Stop.
// - Normal Request auto after Reset, Stop wake-up.
// - Standby: main regulator only, pass drive off.
// - Standby: no CAN transmit, bus wake flag, watchdog runs.
// - Normal: all on; host clears watchdog.
// - Stop: pass drive off, main keep-alive.
// - Stop wakes also on chip-select, overcurrent.
// - Stop watchdog per watchdog-in-stop select.
// - Stop only by host command.
// - Sleep: regulators off; inputs, cyclic, timer, CAN wake.
// - Sleep wake-up passes through Reset.
// - Reset holds reset output low for hold time.
// - Reset on undervoltage, watchdog timeout, early trigger.
// - Power-up via Reset; Stop wake-up skips it.
// - Normal Request: main on, secondary off, timeout starts.
// - Period write ends timeout, enters Normal/Standby.
// - Timeout after power-up/Stop wake-up re-enters Reset.
// - Timeout after Sleep wake-up returns to Sleep.
// - Stop wake-up pulses interrupt low in Normal Request.
package somc_pkg;

    localparam int unsigned CLK_HZ             = 25_000_000;
    localparam int unsigned RESET_HOLD_US      = 15_000;
    localparam int unsigned WAKE_CFG_TOUT_MS   = 350;
    localparam int unsigned WAKE_PULSE_US      = 10;
    localparam int unsigned CYCLIC_PERIOD_US   = 20_000;
    localparam int unsigned CYCLIC_ON_US       = 1_000;
    localparam int unsigned WD_UNIT_US         = 10_000;

    localparam int unsigned RESET_HOLD_CYC  = RESET_HOLD_US * (CLK_HZ / 1_000_000);
    localparam int unsigned WAKE_CFG_CYC    = WAKE_CFG_TOUT_MS * (CLK_HZ / 1_000);
    localparam int unsigned WAKE_PULSE_CYC  = WAKE_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CYCLIC_PER_CYC  = CYCLIC_PERIOD_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CYCLIC_ON_CYC   = CYCLIC_ON_US * (CLK_HZ / 1_000_000);
    localparam int unsigned WD_UNIT_CYC     = WD_UNIT_US * (CLK_HZ / 1_000_000);

    localparam int unsigned CNT_W     = 24;
    localparam int unsigned WAKE_IN_W = 4;
    localparam int unsigned WD_SEL_W  = 2;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 24'h000001;

    typedef enum logic [5:0] {
        SOMC_RESET    = 6'h01,
        SOMC_NORM_REQ = 6'h02,
        SOMC_NORMAL   = 6'h04,
        SOMC_STANDBY  = 6'h08,
        SOMC_STOP     = 6'h10,
        SOMC_SLEEP    = 6'h20
    } somc_mode_t;

    typedef enum logic [1:0] {
        SOMC_ORIGIN_POWER = 2'h0,
        SOMC_ORIGIN_SLEEP = 2'h1,
        SOMC_ORIGIN_STOP  = 2'h2
    } somc_origin_t;

endpackage : somc_pkg

// ### verification/somc_host_model.sv
// Host model: configures and services the watchdog.
`timescale 1ns/100ps
`default_nettype none
module somc_host_model
    import somc_pkg::*;
(
    input wire logic            clk_i,
    input wire logic            reset_i,
    input wire logic            en_i,
    input wire logic            early_i,
    input wire somc_mode_t      mode_i,
    output logic                cfg_wd_write_o,
    output logic [WD_SEL_W-1:0] cfg_wd_period_o,
    output logic                wd_clear_o
);
    logic [7:0] cnt_reg;
    assign cfg_wd_period_o = 2'h0;
    always_ff @(posedge clk_i)
    begin
        cfg_wd_write_o <= 1'b0;
        wd_clear_o     <= 1'b0;
        cnt_reg        <= cnt_reg + 8'h01;
        if (reset_i || !en_i || !(mode_i inside {SOMC_NORM_REQ, SOMC_NORMAL, SOMC_STANDBY}))
            cnt_reg <= 8'h00;
        else if (mode_i == SOMC_NORM_REQ && cnt_reg == 8'h0A)
        begin
            cfg_wd_write_o <= 1'b1;
            cnt_reg        <= 8'h00;
        end
        else if (mode_i != SOMC_NORM_REQ && cnt_reg == (early_i ? 8'h08 : 8'h30))
        begin
            wd_clear_o <= 1'b1;
            cnt_reg    <= 8'h00;
        end
    end
endmodule : somc_host_model
`default_nettype wire

// ### verification/somc_mode_ctrl_checker.sv
// Assertions for the mode controller.
`timescale 1ns/100ps
`default_nettype none
module somc_mode_ctrl_checker
    import somc_pkg::*;
#(
    parameter int unsigned RESET_HOLD_CYCLES = RESET_HOLD_CYC,
    parameter int unsigned WAKE_CFG_CYCLES   = WAKE_CFG_CYC
)
(
    // Clock, reset and host side.
    input wire logic       clk_i, reset_i, cfg_wd_write_i, cfg_goto_standby_i, cmd_stop_i,
    input wire logic       chip_select_n_i, switch_on_control_i,
    // Design outputs.
    input wire logic       reset_n_o, irq_n_o, main_reg_on_o, pass_transistor_drive_o,
    input wire logic       can_tx_enable_o, slow_osc_select_o, high_side_switch_o, switch_overtemp_flag_o,
    input wire somc_mode_t mode_o
);
    logic [CNT_W-1:0] rst_cnt_reg, nr_cnt_reg;
    // Dwell counters; Reset must last the hold time, Normal Request must stay short.
    always_ff @(posedge clk_i)
    begin
        rst_cnt_reg <= (mode_o == SOMC_RESET) ? rst_cnt_reg + CNT_ONE : CNT_ZERO;
        nr_cnt_reg  <= (mode_o == SOMC_NORM_REQ && !reset_i) ? nr_cnt_reg + CNT_ONE : CNT_ZERO;
        if (reset_i)
            rst_cnt_reg <= CNT_ONE;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    AST_RESET_PIN: assert property (reset_n_o == (mode_o != SOMC_RESET && mode_o != SOMC_SLEEP))
        else $error("reset pin wrong");
    AST_RESET_HOLD: assert property (mode_o == SOMC_NORM_REQ && $past(mode_o) == SOMC_RESET |->
        rst_cnt_reg >= RESET_HOLD_CYCLES) else $error("reset mode left too early");
    AST_NR_OUT: assert property (mode_o == SOMC_NORM_REQ |-> main_reg_on_o && !pass_transistor_drive_o)
        else $error("NR supplies");
    AST_NR_TOUT: assert property (nr_cnt_reg <= WAKE_CFG_CYCLES + 2)
        else $error("NR too long");
    AST_CFG_WRITE: assert property (mode_o == SOMC_NORM_REQ && cfg_wd_write_i |=>
        mode_o == ($past(cfg_goto_standby_i) ? SOMC_STANDBY : SOMC_NORMAL)) else $error("config not taken");
    AST_NORMAL: assert property (mode_o == SOMC_NORMAL |-> main_reg_on_o && pass_transistor_drive_o &&
        can_tx_enable_o) else $error("normal mode outputs wrong");
    AST_STANDBY: assert property (mode_o == SOMC_STANDBY |-> main_reg_on_o && !pass_transistor_drive_o &&
        !can_tx_enable_o) else $error("standby outputs wrong");
    AST_OSC: assert property (slow_osc_select_o == (mode_o == SOMC_SLEEP || mode_o == SOMC_STOP))
        else $error("oscillator choice wrong");
    AST_STOP_CMD: assert property ($rose(mode_o == SOMC_STOP) |-> $past(cmd_stop_i))
        else $error("stop uncommanded");
    AST_CS_WAKE: assert property (mode_o == SOMC_STOP && $rose(chip_select_n_i) |->
        ##[2:8] mode_o == SOMC_NORM_REQ) else $error("no CS wake");
    AST_IRQ_PULSE: assert property ($fell(irq_n_o) |-> mode_o == SOMC_NORM_REQ ##1 !irq_n_o [*8])
        else $error("wake pulse wrong");
    AST_SWITCH: assert property ((mode_o == SOMC_NORMAL && !switch_overtemp_flag_o &&
        $stable(switch_on_control_i)) [*4] |-> high_side_switch_o == switch_on_control_i)
        else $error("switch wrong");
endmodule : somc_mode_ctrl_checker
bind somc_mode_ctrl somc_mode_ctrl_checker #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES),
    .WAKE_CFG_CYCLES(WAKE_CFG_CYCLES)) i_somc_mode_ctrl_checker (.clk_i, .reset_i, .cfg_wd_write_i,
    .cfg_goto_standby_i, .cmd_stop_i, .chip_select_n_i, .switch_on_control_i, .reset_n_o, .irq_n_o,
    .main_reg_on_o, .pass_transistor_drive_o, .can_tx_enable_o, .slow_osc_select_o, .high_side_switch_o,
    .switch_overtemp_flag_o, .mode_o);
`default_nettype wire

// ### verification/tb.sv
// Bench for the mode controller.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import somc_pkg::*;
    localparam int unsigned RH = 20, WC = 100, CP = 40, WU = 64;
    typedef struct packed { logic [1:0] k; somc_mode_t m; logic [4:0] outs; } somc_row_t;
    localparam somc_row_t ROWS [4] = '{'{2'h1, SOMC_STANDBY, 5'h02}, '{2'h1, SOMC_STANDBY, 5'h02},
        '{2'h0, SOMC_NORMAL, 5'h0E}, '{2'h0, SOMC_NORMAL, 5'h0E}};
    logic clk_i, reset_i, link_clk_i, link_reset_i, can_rx_frame_i, host_en, host_early;
    logic cfg_wd_write_i, cfg_goto_standby_i, wd_clear_i, forced_wake_i, main_overcurrent_i;
    logic cmd_normal_i, cmd_standby_i, cmd_stop_i, cmd_sleep_i, chip_select_n_i;
    logic switch_on_control_i, watchdog_in_stop_select_i, cyclic_sense_en_i;
    logic main_uv_i, secondary_supply_uv_i, switch_overtemp_i;
    logic reset_n_o, irq_n_o, main_reg_on_o, main_reg_lowpower_o, pass_transistor_drive_o;
    logic high_side_switch_o, can_tx_enable_o, slow_osc_select_o, secondary_supply_low_flag_o;
    logic switch_overtemp_flag_o, switch_overtemp_or_supply_low_irq_flag_o, bus_wake_flag_o;
    logic [WD_SEL_W-1:0] cfg_wd_period_i;
    logic [WAKE_IN_W-1:0] wake_inputs_i, wake_inputs_o;
    logic [4:0] outs;
    somc_mode_t mode_o;
    int bad_count, cmp_count;
    assign outs = {slow_osc_select_o, pass_transistor_drive_o, can_tx_enable_o, reset_n_o, main_reg_lowpower_o};
    somc_mode_ctrl #(.RESET_HOLD_CYCLES(RH), .WAKE_CFG_CYCLES(WC), .CYCLIC_PER_CYCLES(CP), .CYCLIC_ON_CYCLES(8),
        .WD_UNIT_CYCLES(WU)) i_somc_mode_ctrl (.clk_i, .reset_i, .cfg_wd_write_i, .cfg_wd_period_i,
        .cfg_goto_standby_i, .cmd_normal_i, .cmd_standby_i, .cmd_stop_i, .cmd_sleep_i, .wd_clear_i,
        .switch_on_control_i, .watchdog_in_stop_select_i, .cyclic_sense_en_i, .forced_wake_i, .main_uv_i,
        .secondary_supply_uv_i, .switch_overtemp_i, .main_overcurrent_i, .chip_select_n_i, .wake_inputs_i,
        .link_clk_i, .link_reset_i, .can_rx_frame_i, .reset_n_o, .irq_n_o, .main_reg_on_o, .main_reg_lowpower_o,
        .pass_transistor_drive_o, .high_side_switch_o, .can_tx_enable_o, .slow_osc_select_o,
        .secondary_supply_low_flag_o, .switch_overtemp_flag_o, .switch_overtemp_or_supply_low_irq_flag_o,
        .bus_wake_flag_o, .wake_inputs_o, .mode_o);
    somc_host_model i_somc_host_model (.clk_i, .reset_i, .en_i(host_en), .early_i(host_early), .mode_i(mode_o),
        .cfg_wd_write_o(cfg_wd_write_i), .cfg_wd_period_o(cfg_wd_period_i), .wd_clear_o(wd_clear_i));
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial
    begin
        link_clk_i = 1'b0;
        #7;
        forever #16 link_clk_i = ~link_clk_i;
    end
    task automatic chk(input bit ok, input string msg);
        cmp_count++;
        if (!ok)
        begin
            bad_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    task automatic wait_mode(input somc_mode_t m, input int lim);
        int n;
        n = 0;
        while (mode_o !== m && n < lim)
        begin
            cyc(1);
            n++;
        end
        if (mode_o !== m)
        begin
            chk(1'b0, "mode wait ran out");
            results();
        end
    endtask : wait_mode
    task automatic cmd(input logic [1:0] k);
        @(posedge clk_i) {cmd_normal_i, cmd_standby_i, cmd_stop_i, cmd_sleep_i} <= 4'h8 >> k;
        @(posedge clk_i) {cmd_normal_i, cmd_standby_i, cmd_stop_i, cmd_sleep_i} <= 4'h0;
        #1;
    endtask : cmd
    initial
    begin
        int n;
        {reset_i, link_reset_i, host_en, chip_select_n_i} = 4'hF;
        {cmd_normal_i, cmd_standby_i, cmd_stop_i, cmd_sleep_i, can_rx_frame_i, host_early} = 6'h00;
        {switch_on_control_i, watchdog_in_stop_select_i, cyclic_sense_en_i, forced_wake_i} = 4'h0;
        {main_uv_i, secondary_supply_uv_i, switch_overtemp_i, main_overcurrent_i, cfg_goto_standby_i} = 5'h00;
        wake_inputs_i = 4'h0;
        bad_count = 0;
        cmp_count = 0;
        cyc(5);
        @(posedge clk_i) {reset_i, link_reset_i} <= 2'h0;
        wait_mode(SOMC_NORMAL, RH + 40);
        foreach (ROWS[i])
        begin
            cmd(ROWS[i].k);
            chk(mode_o === ROWS[i].m && outs === ROWS[i].outs, "command row");
        end
        $display("rows done");
        @(posedge clk_i) switch_on_control_i <= 1'b1;
        cyc(5);
        chk(high_side_switch_o === 1'b1, "switch not on");
        @(posedge clk_i) secondary_supply_uv_i <= 1'b1;
        cyc(6);
        chk(secondary_supply_low_flag_o === 1'b1 && switch_overtemp_or_supply_low_irq_flag_o === 1'b1, "low");
        @(posedge clk_i) {secondary_supply_uv_i, switch_overtemp_i} <= 2'h1;
        cyc(6);
        chk({switch_overtemp_flag_o, switch_overtemp_or_supply_low_irq_flag_o, high_side_switch_o} === 3'h6, "ot");
        @(posedge clk_i) {switch_overtemp_i, switch_on_control_i} <= 2'h0;
        cmd(2'h1);
        @(posedge link_clk_i) can_rx_frame_i <= 1'b1;
        @(posedge link_clk_i) can_rx_frame_i <= 1'b0;
        cyc(10);
        chk(bus_wake_flag_o === 1'b1 && can_tx_enable_o === 1'b0, "bus wake");
        cmd(2'h0);
        cyc(2);
        chk(bus_wake_flag_o === 1'b0, "wake kept");
        $display("standby done");
        cmd(2'h2);
        chk(mode_o === SOMC_STOP && outs === 5'h13, "stop outputs");
        cyc(4 * WU);
        chk(mode_o === SOMC_STOP, "halted watchdog fired");
        @(posedge clk_i) chip_select_n_i <= 1'b0;
        cyc(3);
        @(posedge clk_i) chip_select_n_i <= 1'b1;
        wait_mode(SOMC_NORM_REQ, 10);
        cmd(2'h2);
        chk(mode_o === SOMC_NORM_REQ && reset_n_o === 1'b1 && irq_n_o === 1'b0, "stop wake");
        wait_mode(SOMC_NORMAL, 30);
        @(posedge clk_i) watchdog_in_stop_select_i <= 1'b1;
        cmd(2'h2);
        wait_mode(SOMC_RESET, 3 * WU);
        wait_mode(SOMC_NORMAL, RH + 40);
        cmd(2'h2);
        @(posedge clk_i) main_overcurrent_i <= 1'b1;
        wait_mode(SOMC_NORM_REQ, 10);
        wait_mode(SOMC_NORMAL, 30);
        $display("stop done");
        @(posedge clk_i) {main_overcurrent_i, cyclic_sense_en_i} <= 2'h1;
        cmd(2'h3);
        chk(outs === 5'h10 && main_reg_on_o === 1'b0, "sleep outputs");
        n = 0;
        while (high_side_switch_o !== 1'b1 && n < CP + 10)
        begin
            cyc(1);
            n++;
        end
        chk(high_side_switch_o === 1'b1, "no cyclic switch pulse");
        @(posedge clk_i) {host_en, wake_inputs_i} <= 5'h01;
        wait_mode(SOMC_RESET, 20);
        chk(wake_inputs_o === 4'h1, "inputs");
        wait_mode(SOMC_NORM_REQ, RH + 10);
        wait_mode(SOMC_SLEEP, WC + 10);
        @(posedge clk_i) {host_en, forced_wake_i} <= 2'h3;
        wait_mode(SOMC_RESET, 20);
        wait_mode(SOMC_NORMAL, RH + 40);
        $display("sleep mode done");
        @(posedge clk_i) host_early <= 1'b1;
        wait_mode(SOMC_RESET, 2 * WU);
        @(posedge clk_i) {host_early, main_uv_i} <= 2'h0;
        wait_mode(SOMC_NORMAL, RH + 40);
        @(posedge clk_i) main_uv_i <= 1'b1;
        wait_mode(SOMC_RESET, 10);
        @(posedge clk_i) {main_uv_i, host_en, reset_i} <= 3'h1;
        cyc(5);
        @(posedge clk_i) reset_i <= 1'b0;
        wait_mode(SOMC_NORM_REQ, RH + 10);
        chk(reset_n_o === 1'b1 && main_reg_on_o === 1'b1 && pass_transistor_drive_o === 1'b0, "nr");
        wait_mode(SOMC_RESET, WC + 10);
        wait_mode(SOMC_NORM_REQ, RH + 10);
        @(posedge clk_i) {host_en, cfg_goto_standby_i} <= 2'h3;
        wait_mode(SOMC_STANDBY, 20);
        $display("faults done");
        results();
    end
endmodule : tb
`default_nettype wire
